// ==== pool_stride_pkg.sv ====
package pool_stride_pkg;

	// Per-layer register ranges: 32 layers, one word each.
	localparam int NumLayers = 32;
	localparam int LayerBits = 5;
	localparam logic [11:0] PoolRowBase = 12'h190;
	localparam logic [11:0] PoolColBase = 12'h210;
	localparam logic [11:0] StrideBase = 12'h290;
	localparam logic [11:0] RangeSpan = 12'h080;

	// Field layout.
	localparam int CountWidth = 4;
	localparam int StrideWidth = 2;
	localparam int PosWidth = 10;
	localparam logic [3:0] CountReset = 4'h0;
	localparam logic [1:0] StrideReset = 2'h0;
	localparam logic [PosWidth-1:0] PosZero = 10'h000;
	localparam logic [PosWidth-1:0] PosOne = 10'h001;

	typedef struct packed {
		logic [CountWidth-1:0] rowMax;
		logic [CountWidth-1:0] colMax;
		logic [StrideWidth-1:0] stride;
	} layer_cfg_t;

	typedef struct packed {
		logic [PosWidth-1:0] row;
		logic [PosWidth-1:0] col;
	} position_t;

	typedef enum logic [1:0] {
		Idle,
		Run,
		Done
	} scan_state_t;

endpackage

// ==== pool_stride_counters.sv ====
// Behaviour
// R1 - Pool row max is 4-bit field 3:0
// R2 - Pool rows start at zero
// R3 - Rows finish after programmed maximum row
// R4 - Rows finish early past image rows
// R5 - Pool row count adds to row position
// R6 - Pool column max is 4-bit field 3:0
// R7 - Pool columns start at zero
// R8 - Columns finish after programmed maximum column
// R9 - Columns finish early past image columns
// R10 - Pool column count adds to column position
// R11 - Stride is 2-bit field, rest zero
// R12 - Step by one until inside unpadded image
// R13 - Then apply the programmed stride
// R14 - Keep stride while field inside image
// R15 - Counters and position clear at layer start
`timescale 1ns/10ps
module pool_stride_counters
	import pool_stride_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Register port, word addressed by byte offset.
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWdata,
	output logic [31:0] regRdata,
	output logic regHit,
	// Layer control.
	input wire logic layerStart,
	input wire logic [LayerBits-1:0] layerSel,
	input wire logic stepEn,
	input wire logic globalPoolEn,
	input wire logic layerPoolEn,
	// Image geometry and padding.
	input wire logic [PosWidth-1:0] imageRows,
	input wire logic [PosWidth-1:0] imageCols,
	input wire logic [PosWidth-1:0] padRows,
	input wire logic [PosWidth-1:0] padCols,
	// Position outputs.
	output logic [CountWidth-1:0] poolRow,
	output logic [CountWidth-1:0] poolCol,
	output position_t pooledPos,
	output position_t fieldPos,
	output logic poolRowDone,
	output logic layerDone,
	output logic busy
);

	// Per-layer configuration, one word per layer and register.
	layer_cfg_t cfg_reg [NumLayers];

	// Scan control.
	scan_state_t state_reg;
	scan_state_t state_next;
	logic [LayerBits-1:0] layer_reg;
	logic busy_reg;
	logic done_reg;
	logic rowDone_reg;

	// Pool window counters, field origin and pooled position.
	logic [CountWidth-1:0] prow_reg;
	logic [CountWidth-1:0] pcol_reg;
	position_t field_reg;
	position_t pooled_reg;

	// Register read port.
	logic [31:0] rdata_reg;
	logic hit_reg;

	// Address decode for the three per-layer ranges.
	wire logic [11:0] rowOff = regAddr - PoolRowBase;
	wire logic [11:0] colOff = regAddr - PoolColBase;
	wire logic [11:0] strOff = regAddr - StrideBase;
	wire logic inRow = regAddr >= PoolRowBase && rowOff < RangeSpan;
	wire logic inCol = regAddr >= PoolColBase && colOff < RangeSpan;
	wire logic inStr = regAddr >= StrideBase && strOff < RangeSpan;
	wire logic [LayerBits-1:0] rowIdx = rowOff[LayerBits+1:2];
	wire logic [LayerBits-1:0] colIdx = colOff[LayerBits+1:2];
	wire logic [LayerBits-1:0] strIdx = strOff[LayerBits+1:2];
	wire logic aligned = regAddr[1:0] == 2'h0;
	wire logic [31:0] rowRd = {28'h0000000, cfg_reg[rowIdx].rowMax};
	wire logic [31:0] colRd = {28'h0000000, cfg_reg[colIdx].colMax};
	wire logic [31:0] strRd = {30'h00000000, cfg_reg[strIdx].stride}; // R11
	wire logic [31:0] rdSel = !aligned ? 32'h00000000 :
		inRow ? rowRd : inCol ? colRd : inStr ? strRd : 32'h00000000;
	wire logic anyHit = aligned && (inRow || inCol || inStr);
	wire logic rowWr = regWrite && anyHit && inRow;
	wire logic colWr = regWrite && anyHit && inCol;
	wire logic strWr = regWrite && anyHit && inStr;
	wire logic [31:0] rdata_next = regRead ? rdSel : 32'h00000000;
	wire logic hit_next = regRead && anyHit;

	// One write decoder and one register set per layer.
	for (genvar g = 0; g < NumLayers; g++) begin : gLayer
		wire logic [LayerBits-1:0] idx = LayerBits'(g);
		wire logic rowWe = rowWr && rowIdx == idx;
		wire logic colWe = colWr && colIdx == idx;
		wire logic strWe = strWr && strIdx == idx;
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				cfg_reg[g] <= '{CountReset, CountReset, StrideReset};
			end else begin
				if (rowWe) begin
					cfg_reg[g].rowMax <= regWdata[CountWidth-1:0]; // R1
				end
				if (colWe) begin
					cfg_reg[g].colMax <= regWdata[CountWidth-1:0]; // R6
				end
				if (strWe) begin
					cfg_reg[g].stride <= regWdata[StrideWidth-1:0]; // R11
				end
			end
		end
	end

	// Active layer configuration; pooling off collapses the window to one.
	wire layer_cfg_t cur = cfg_reg[layer_reg];
	wire logic poolOn = globalPoolEn || layerPoolEn;
	wire logic [CountWidth-1:0] rowMax = poolOn ? cur.rowMax : CountReset; // R1
	wire logic [CountWidth-1:0] colMax = poolOn ? cur.colMax : CountReset; // R6

	// Pooled position is the field origin plus the pool offsets.
	wire logic [PosWidth-1:0] effRow = field_reg.row + PosWidth'(prow_reg); // R5
	wire logic [PosWidth-1:0] effCol = field_reg.col + PosWidth'(pcol_reg); // R10
	wire logic colEnd = pcol_reg == colMax || effCol + PosOne >= imageCols; // R8 R9
	wire logic rowEnd = prow_reg == rowMax || effRow + PosOne >= imageRows; // R3 R4

	// Stride stepping: unit steps inside the padding, programmed stride after.
	wire logic [PosWidth-1:0] strideVal = PosWidth'(cur.stride) + PosOne;
	wire logic colInside = field_reg.col >= padCols; // R12
	wire logic rowInside = field_reg.row >= padRows; // R12
	wire logic [PosWidth-1:0] colStep = colInside ? strideVal : PosOne; // R13
	wire logic [PosWidth-1:0] rowStep = rowInside ? strideVal : PosOne; // R13
	wire logic [PosWidth-1:0] nextCol = field_reg.col + colStep;
	wire logic [PosWidth-1:0] nextRow = field_reg.row + rowStep;
	// Stride applies only while the next field origin stays in the image.
	wire logic colWrap = nextCol >= imageCols; // R14
	wire logic rowWrap = nextRow >= imageRows; // R14
	wire logic windowEnd = colEnd && rowEnd;

	// A layer start outranks a step taken in the same cycle.
	wire logic stepNow = state_reg == Run && stepEn && !layerStart;
	// The last step is the one that finds no further field origin.
	wire logic lastStep = stepNow && windowEnd && colWrap && rowWrap; // R3 R4

	// Column inner, then pool row, then the field walk.
	wire logic [CountWidth-1:0] pcolInc = pcol_reg + 4'h1;
	wire logic [CountWidth-1:0] prowInc = prow_reg + 4'h1;
	wire logic [CountWidth-1:0] pcolStep =
		colEnd ? CountReset : pcolInc; // R7 R8
	wire logic [CountWidth-1:0] prowStep =
		!colEnd ? prow_reg : rowEnd ? CountReset : prowInc; // R2 R3
	wire position_t fieldStep =
		!windowEnd ? field_reg :
		!colWrap ? {field_reg.row, nextCol} : // R13
		!rowWrap ? {nextRow, PosZero} : field_reg; // R13

	// Next values; a layer start clears the window and the field.
	wire logic [CountWidth-1:0] pcol_next =
		layerStart ? CountReset : stepNow ? pcolStep : pcol_reg; // R7 R15
	wire logic [CountWidth-1:0] prow_next =
		layerStart ? CountReset : stepNow ? prowStep : prow_reg; // R2 R15
	wire position_t field_next = layerStart ? {PosZero, PosZero} : // R15
		stepNow ? fieldStep : field_reg;
	wire logic [LayerBits-1:0] layer_next =
		layerStart ? layerSel : layer_reg;
	wire logic busy_next = state_next == Run;
	wire logic done_next = lastStep;
	wire logic rowDone_next = stepNow && colEnd; // R8 R9
	wire position_t pooled_next = {effRow, effCol}; // R5 R10

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			Idle: begin
				if (layerStart) begin
					state_next = Run;
				end
			end
			Run: begin
				if (lastStep) begin
					state_next = Done;
				end
			end
			Done: begin
				if (layerStart) begin
					state_next = Run;
				end
			end
			default: begin
				state_next = Idle;
			end
		endcase
	end

	// Register read port answers the cycle after the strobe.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= rdata_next; // R11
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hit_reg <= 1'b0;
		end else begin
			hit_reg <= hit_next;
		end
	end

	// Busy is registered so the pin never shows decode glitches.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= Idle;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			layer_reg <= '0;
		end else begin
			layer_reg <= layer_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= busy_next;
		end
	end

	// Layer done is a single-cycle pulse; row done is set after each step that ends a pool row.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rowDone_reg <= 1'b0;
		end else begin
			rowDone_reg <= rowDone_next;
		end
	end

	// Pool window counters and receptive field origin.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prow_reg <= CountReset;
		end else begin
			prow_reg <= prow_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pcol_reg <= CountReset;
		end else begin
			pcol_reg <= pcol_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			field_reg <= '{PosZero, PosZero};
		end else begin
			field_reg <= field_next;
		end
	end

	// The pooled position lags the counters by one cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pooled_reg <= '{PosZero, PosZero};
		end else begin
			pooled_reg <= pooled_next;
		end
	end

	// Outputs straight from the registers.
	assign regRdata = rdata_reg;
	assign regHit = hit_reg;
	assign poolRow = prow_reg;
	assign poolCol = pcol_reg;
	assign pooledPos = pooled_reg;
	assign fieldPos = field_reg;
	assign poolRowDone = rowDone_reg;
	assign layerDone = done_reg;
	assign busy = busy_reg;

endmodule

// ==== pool_stride_chk.sv ====
`timescale 1ns/10ps
module pool_stride_chk
	import pool_stride_pkg::*;
(
	// Watched ports.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic regRead,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regRdata,
	input wire logic regHit,
	input wire logic layerStart,
	input wire logic stepEn,
	input wire logic [CountWidth-1:0] poolRow,
	input wire logic [CountWidth-1:0] poolCol,
	input wire position_t pooledPos,
	input wire position_t fieldPos,
	input wire logic layerDone,
	input wire logic poolRowDone,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire mapped = regAddr >= PoolRowBase && regAddr[1:0] == 2'h0 &&
		regAddr < StrideBase + RangeSpan;
	AST_HIT: assert property (regRead && mapped |=> regHit)
		else $error("mapped read gave no hit");
	AST_IDLE_BUS: assert property (!regRead |=> regRdata == 32'h0 && !regHit)
		else $error("read data not zero without a read");
	AST_RSVD: assert property (regHit |-> regRdata[31:4] == 28'h0)
		else $error("reserved count bits not zero");
	AST_STRIDE_RSVD: assert property (regRead && regAddr >= StrideBase |=>
		regRdata[31:2] == 30'h0) else $error("reserved stride bits set");
	AST_START: assert property (layerStart |=> busy && poolRow == 4'h0 &&
		poolCol == 4'h0 && fieldPos == 20'h0) else $error("bad layer start");
	AST_DONE: assert property (layerDone |=> !layerDone)
		else $error("layer done longer than one cycle");
	AST_PROW: assert property ($past(busy) |-> pooledPos.row ==
		$past(fieldPos.row) + 10'($past(poolRow))) else $error("pooled row");
	AST_PCOL: assert property ($past(busy) |-> pooledPos.col ==
		$past(fieldPos.col) + 10'($past(poolCol))) else $error("pooled col");
	// A step either advances the column by one or wraps it to zero.
	AST_STEP: assert property (busy && stepEn && !layerStart ##1 busy |->
		poolCol == $past(poolCol) + 4'h1 || poolCol == 4'h0)
		else $error("pool column skipped");
	AST_HOLD: assert property (busy && !stepEn && !layerStart |=>
		$stable(poolRow) && $stable(poolCol) && $stable(fieldPos))
		else $error("position moved without a step");
	AST_ROWDONE: assert property (poolRowDone |-> poolCol == 4'h0)
		else $error("pool column not wrapped at row end");
	cover property (layerDone);
	cover property (regHit);
	cover property (busy && poolCol != 4'h0);
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top import pool_stride_pkg::*; ();
	logic clk = 0, rst_n = 0, regWrite = 0, regRead = 0, layerStart = 0;
	logic stepEn = 0, globalPoolEn = 0, layerPoolEn = 0, rdSeen = 0;
	logic [11:0] regAddr = 12'h000, a;
	logic [31:0] regWdata = 32'h0, regRdata, steps = 32'h0, d, q[$];
	logic [LayerBits-1:0] layerSel = 5'h00;
	logic [PosWidth-1:0] imageRows = 10'h000, imageCols = 10'h000;
	logic [PosWidth-1:0] padRows = 10'h000, padCols = 10'h000;
	logic [CountWidth-1:0] poolRow, poolCol;
	position_t pooledPos, fieldPos;
	logic regHit, poolRowDone, layerDone, busy;
	int errTotal = 0, checked = 0, i, k;
	pool_stride_counters pool_stride_counters_i (.clk, .rst_n, .regWrite,
		.regRead, .regAddr, .regWdata, .regRdata, .regHit, .layerStart,
		.layerSel, .stepEn, .globalPoolEn, .layerPoolEn, .imageRows,
		.imageCols, .padRows, .padCols, .poolRow, .poolCol, .pooledPos,
		.fieldPos, .poolRowDone, .layerDone, .busy);
	initial forever #2 clk = ~clk;
	function automatic logic [31:0] cnt(input logic [9:0] p, n, input int s);
		return 32'(p) + (32'(n - p) + 32'(s)) / 32'(s + 1);
	endfunction
	task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
		checked++;
		if (seen !== e) begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", n, e, seen);
		end
	endtask
	task finalReport;
		$display("checks %0d mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task acc(input logic w, input logic [11:0] ad, input logic [31:0] dv, e);
		regWrite = w;
		regRead = !w;
		regAddr = ad;
		regWdata = dv;
		if (!w) q.push_back(e);
		@(negedge clk);
		regWrite = 1'b0;
		regRead = 1'b0;
		@(negedge clk);
	endtask
	task run(input logic [1:0] pe, input logic [31:0] e);
		{globalPoolEn, layerPoolEn} = pe;
		if (pe == 2'h0) q.push_back(e);
		layerStart = 1'b1;
		@(negedge clk);
		layerStart = 1'b0;
		for (i = 0; i < 8000 && !layerDone; i++) begin
			stepEn = 1'($urandom);
			@(negedge clk);
		end
		if (!layerDone) errTotal++;
		stepEn = 1'b0;
	endtask
	always @(posedge clk) rdSeen <= regRead;
	always @(posedge clk)
		if (layerStart) steps <= 32'h0;
		else if (busy && stepEn) steps <= steps + 32'h1;
	always @(negedge clk) begin
		if (rdSeen) chk("regRdata", regRdata, q.pop_front());
		if (layerDone && !globalPoolEn && !layerPoolEn)
			chk("steps", steps, q.pop_front());
	end
	initial begin
		k = $urandom(47419);
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		for (k = 0; k < 7; k++) begin
			a = k < 4 ? PoolRowBase + 12'(k) * 12'h080 + 12'h07C : 12'h310 + 12'(k);
			acc(1'b0, a, 32'h0, 32'h0);
		end
		for (k = 0; k < 12; k++) begin
			a = PoolRowBase + 12'(k % 3) * RangeSpan + 12'($urandom % 32) * 12'h4;
			d = $urandom;
			acc(1'b1, a, d, 32'h0);
			acc(1'b0, a, d, d & (k % 3 == 2 ? 32'h3 : 32'hF));
		end
		$display("test regs done");
		for (k = 0; k < 7; k++) begin
			layerSel = 5'($urandom);
			a = 12'({layerSel, 2'h0});
			d = $urandom;
			acc(1'b1, StrideBase + a, d, 32'h0);
			acc(1'b1, PoolRowBase + a, 32'($urandom % 4), 32'h0);
			acc(1'b1, PoolColBase + a, 32'($urandom % 4), 32'h0);
			imageRows = 10'(4 + $urandom % 9);
			imageCols = 10'(4 + $urandom % 9);
			padRows = 10'($urandom % 4);
			padCols = 10'($urandom % 4);
			run(k < 4 ? 2'h0 : 2'(k - 3), cnt(padRows, imageRows, int'(d[1:0]))
				* cnt(padCols, imageCols, int'(d[1:0])));
		end
		$display("test scan done");
		finalReport;
	end
	// Seven scans of at most 8000 cycles each plus the register tests.
	initial begin
		#240000;
		errTotal++;
		finalReport;
	end
endmodule
bind pool_stride_counters pool_stride_chk pool_stride_chk_i (.clk, .rst_n,
	.regRead, .regAddr, .regRdata, .regHit, .layerStart, .stepEn, .poolRow,
	.poolCol, .pooledPos, .fieldPos, .layerDone, .poolRowDone, .busy);
